//--- logic/vfm_consts.svh
// Constants for the VBUS fault monitor: thresholds, times and clock rate.
// Assumes voltage codes of 10 mV of VBUS per LSB and current-sense codes of 1 mV per LSB.
`ifndef VFM_CONSTS_SVH
`define VFM_CONSTS_SVH
`define VFM_CLK_KHZ 25000
`define VFM_V_W 12
`define VFM_I_W 12
`define VFM_CNT_W 27
// Transition thresholds in 10 mV units: 3 V on, 2 V off
`define VFM_V_PON 12'h12c
`define VFM_V_POFF 12'h0c8
// Overvoltage limits: 6.0, 10.4, 13.7, 18.1, 22.5 V
`define VFM_OV_5 12'h258
`define VFM_OV_9 12'h410
`define VFM_OV_12 12'h55a
`define VFM_OV_16 12'h712
`define VFM_OV_20 12'h8ca
// Undervoltage limits: 4.5, 8.1, 10.8, 14.4, 18.0 V
`define VFM_UV_5 12'h1c2
`define VFM_UV_9 12'h32a
`define VFM_UV_12 12'h438
`define VFM_UV_16 12'h5a0
`define VFM_UV_20 12'h708
// Sense scale: 3000 mV means 6.0 A, so a code is half the current in mA
`define VFM_I_SENSE_MV 3000
`define VFM_I_SENSE_MA 6000
// Overcurrent limits in sense mV: 1.73, 2.30, 3.45, 5.75 A and default
`define VFM_OC_1A5 12'h361
`define VFM_OC_2A 12'h47e
`define VFM_OC_3A 12'h6bd
`define VFM_OC_5A 12'hb3b
`define VFM_OC_DEF 12'h6bd
// Times in ms
`define VFM_TRANS_MS 275
`define VFM_STROBE_MS 500
`define VFM_LONG_MS 5000
`define VFM_WIN_MS 4000
`define VFM_PULSE_MS 1
`define VFM_EXC_MAX 3'h3
`endif

//--- logic/vfm_monitor.sv
// VBUS supply supervisor: transitions, over/undervoltage, overcurrent, fault strobe.
// Assumes sense codes come from ADC logic on clk_in; the sink-fault pin is asynchronous.
// Function
// - Power-on is complete once sensed VBUS reaches 3 V.
// - Power-off is complete, supply discharged, once sensed VBUS falls to 2 V.
// - A timer supervises each transition; timeout holds fault low until completion.
// - Flag overvoltage above the limit of the present nominal level.
// - Flag undervoltage below the limit of the present nominal level.
// - Any over/undervoltage, overcurrent or sink fault switches the supply off and commands discharge; a transition timeout does not.
// - After a fault, strobe the active-low fault output about every 500 ms.
// - More than 3 faults within 4 s stretch the strobe interval to 5 s.
// - Current-sense reading of 3.0 V means 6.0 A on VBUS.
// - With a contract, the overcurrent limit follows the negotiated current.
// - With no partner attached, a default overcurrent limit applies.
// - Current is checked only while sourcing; the sink-fault input counts as a fault.
`timescale 1ns/1ns
`default_nettype none
`include "vfm_consts.svh"
module vfm_monitor
  import vfm_pkg::*;
#(
  parameter int unsigned TRANS_CYC = `VFM_TRANS_MS * `VFM_CLK_KHZ,
  parameter int unsigned STROBE_CYC = `VFM_STROBE_MS * `VFM_CLK_KHZ,
  parameter int unsigned LONG_CYC = `VFM_LONG_MS * `VFM_CLK_KHZ,
  parameter int unsigned WIN_CYC = `VFM_WIN_MS * `VFM_CLK_KHZ,
  parameter int unsigned PULSE_CYC = `VFM_PULSE_MS * `VFM_CLK_KHZ
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Sense codes
  input wire logic [`VFM_V_W-1:0] vbus_voltage_sense_in,
  input wire logic [`VFM_I_W-1:0] supply_current_sense_in,
  input wire logic external_sink_fault_in,
  // Policy
  input wire logic power_on_req_in,
  input wire logic [2:0] level_sel_in,
  input wire logic [1:0] contract_current_in,
  input wire logic contract_valid_in,
  input wire logic partner_attached_in,
  input wire logic sourcing_in,
  // Supply control and status
  output logic supply_en_out,
  output logic discharge_out,
  output logic fault_n_out,
  output logic power_good_out
);
  vfm_state_type state_q, state_d;
  logic [`VFM_CNT_W-1:0] tmr_q, tmr_d, int_q, int_d, win_q, win_d, pul_q, pul_d;
  logic [2:0] exc_q, exc_d, sync_q, sync_d;
  logic ext_q, ext_d, to_q, to_d;
  logic uv_arm_q, uv_arm_d;
  logic en_q, en_d, dis_q, dis_d, fn_q, fn_d, pg_q, pg_d;
  logic [`VFM_V_W-1:0] ov_lim, uv_lim;
  logic [`VFM_I_W-1:0] oc_lim;
  logic ov, uv, oc, fault_ev, enter_fault;

  always_comb begin
    case (vfm_level_type'(level_sel_in))
      VFM_LVL_9: begin ov_lim = `VFM_OV_9; uv_lim = `VFM_UV_9; end
      VFM_LVL_12: begin ov_lim = `VFM_OV_12; uv_lim = `VFM_UV_12; end
      VFM_LVL_16: begin ov_lim = `VFM_OV_16; uv_lim = `VFM_UV_16; end
      VFM_LVL_20: begin ov_lim = `VFM_OV_20; uv_lim = `VFM_UV_20; end
      default: begin ov_lim = `VFM_OV_5; uv_lim = `VFM_UV_5; end
    endcase
    // Sense code is in mV, half the current in mA
    if (!partner_attached_in || !contract_valid_in) begin
      oc_lim = `VFM_OC_DEF;
    end else begin
      case (vfm_current_type'(contract_current_in))
        VFM_CUR_1A5: oc_lim = `VFM_OC_1A5;
        VFM_CUR_2A: oc_lim = `VFM_OC_2A;
        VFM_CUR_3A: oc_lim = `VFM_OC_3A;
        default: oc_lim = `VFM_OC_5A;
      endcase
    end
    ov = vbus_voltage_sense_in > ov_lim;
    uv = vbus_voltage_sense_in < uv_lim;
    oc = sourcing_in && (supply_current_sense_in > oc_lim);
  end

  always_comb begin
    sync_d = {sync_q[1:0], external_sink_fault_in};
    ext_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : ext_q;
    state_d = state_q;
    tmr_d = tmr_q;
    to_d = to_q;
    fault_ev = 1'b0;
    case (state_q)
      VFM_OFF: begin
        if (power_on_req_in) begin
          state_d = VFM_RAMP_ON;
          tmr_d = '0;
        end
      end
      VFM_RAMP_ON: begin
        tmr_d = tmr_q + 1'b1;
        if (ov || ext_q) begin
          fault_ev = 1'b1;
        end else if (!power_on_req_in) begin
          state_d = VFM_RAMP_OFF;
          tmr_d = '0;
        end else if (vbus_voltage_sense_in >= `VFM_V_PON) begin
          state_d = VFM_ON;
          to_d = 1'b0;
        end
      end
      VFM_ON: begin
        // Undervoltage counts only once VBUS has risen past the limit
        if (ov || (uv && uv_arm_q) || oc || ext_q) begin
          fault_ev = 1'b1;
        end else if (!power_on_req_in) begin
          state_d = VFM_RAMP_OFF;
          tmr_d = '0;
        end
      end
      VFM_RAMP_OFF: begin
        tmr_d = tmr_q + 1'b1;
        if (vbus_voltage_sense_in <= `VFM_V_POFF) begin
          state_d = VFM_OFF;
          to_d = 1'b0;
        end
      end
      VFM_FAULT: begin
        if (!power_on_req_in && vbus_voltage_sense_in <= `VFM_V_POFF) begin
          state_d = VFM_OFF;
        end
      end
      default: state_d = VFM_OFF;
    endcase
    if (fault_ev) begin
      state_d = VFM_FAULT;
    end
    if ((state_d == VFM_RAMP_ON || state_d == VFM_RAMP_OFF) &&
        tmr_q == `VFM_CNT_W'(TRANS_CYC - 1)) begin
      to_d = 1'b1;
    end
    enter_fault = fault_ev;
    // Exception count, cleared when the window runs out
    exc_d = exc_q;
    win_d = win_q;
    if (enter_fault) begin
      win_d = `VFM_CNT_W'(WIN_CYC - 1);
      exc_d = (win_q == '0) ? 3'h1 : ((exc_q == 3'h7) ? exc_q : exc_q + 3'h1);
    end else if (win_q != '0) begin
      win_d = win_q - 1'b1;
      if (win_q == `VFM_CNT_W'(1)) begin
        exc_d = 3'h0;
      end
    end
    // Strobe timing while in fault
    int_d = int_q;
    pul_d = (pul_q != '0) ? pul_q - 1'b1 : pul_q;
    if (enter_fault) begin
      int_d = '0;
    end else if (state_q == VFM_FAULT) begin
      if (int_q == '0) begin
        int_d = (exc_q > `VFM_EXC_MAX) ? `VFM_CNT_W'(LONG_CYC - 1)
                                         : `VFM_CNT_W'(STROBE_CYC - 1);
        pul_d = `VFM_CNT_W'(PULSE_CYC);
      end else begin
        int_d = int_q - 1'b1;
      end
    end
    en_d = (state_d == VFM_RAMP_ON) || (state_d == VFM_ON);
    dis_d = (state_d == VFM_RAMP_OFF) || (state_d == VFM_FAULT);
    fn_d = !((pul_d != '0) || to_d);
    pg_d = state_d == VFM_ON;
    uv_arm_d = (state_d == VFM_ON) && (uv_arm_q || !uv);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= VFM_OFF;
      tmr_q <= '0;
      int_q <= '0;
      win_q <= '0;
      pul_q <= '0;
      exc_q <= 3'h0;
      sync_q <= 3'h0;
      ext_q <= 1'b0;
      to_q <= 1'b0;
      en_q <= 1'b0;
      dis_q <= 1'b0;
      fn_q <= 1'b1;
      pg_q <= 1'b0;
      uv_arm_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      int_q <= int_d;
      win_q <= win_d;
      pul_q <= pul_d;
      exc_q <= exc_d;
      sync_q <= sync_d;
      ext_q <= ext_d;
      to_q <= to_d;
      en_q <= en_d;
      dis_q <= dis_d;
      fn_q <= fn_d;
      pg_q <= pg_d;
      uv_arm_q <= uv_arm_d;
    end
  end

  assign supply_en_out = en_q;
  assign discharge_out = dis_q;
  assign fault_n_out = fn_q;
  assign power_good_out = pg_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_fault_entry;
    state_q != VFM_FAULT ##1 state_q == VFM_FAULT;
  endsequence

  a_pon_done: assert property (state_q == VFM_RAMP_ON && power_on_req_in && !ov && !ext_q
    && vbus_voltage_sense_in >= `VFM_V_PON |=> state_q == VFM_ON && power_good_out)
    else $error("power-on not completed at threshold");
  a_poff_done: assert property (state_q == VFM_RAMP_OFF && vbus_voltage_sense_in <= `VFM_V_POFF
    |=> state_q == VFM_OFF && !discharge_out)
    else $error("power-off not completed at threshold");
  a_trans_timeout: assert property ((state_q == VFM_RAMP_ON || state_q == VFM_RAMP_OFF)
    && state_d == state_q && tmr_q == `VFM_CNT_W'(TRANS_CYC - 1) |=> !fault_n_out)
    else $error("transition timeout did not assert fault");
  a_ov_trip: assert property (state_q == VFM_ON && ov |=> state_q == VFM_FAULT)
    else $error("overvoltage not trapped");
  a_uv_trip: assert property (state_q == VFM_ON && uv_arm_q && uv |=> state_q == VFM_FAULT)
    else $error("undervoltage not trapped");
  a_uv_armed: assert property (state_q == VFM_ON && !uv && state_d == VFM_ON |=> uv_arm_q)
    else $error("undervoltage check not armed");
  a_fault_off: assert property (s_fault_entry |-> !supply_en_out && discharge_out)
    else $error("supply not off during fault");
  a_first_strobe: assert property (s_fault_entry |=> !fault_n_out)
    else $error("no strobe after fault entry");
  a_long_gap: assert property (state_q == VFM_FAULT && int_q == '0 && exc_q > `VFM_EXC_MAX
    && !fault_ev |=> int_q == `VFM_CNT_W'(LONG_CYC - 1))
    else $error("long strobe interval not used");
  a_oc_trip: assert property (state_q == VFM_ON && sourcing_in && partner_attached_in
    && contract_valid_in && supply_current_sense_in > oc_lim |=> state_q == VFM_FAULT)
    else $error("overcurrent not trapped");
  a_oc_default: assert property (!partner_attached_in |-> oc_lim == `VFM_OC_DEF)
    else $error("default overcurrent limit not applied");
  a_sink_fault: assert property (state_q == VFM_ON && ext_q |=> state_q == VFM_FAULT)
    else $error("sink fault not trapped");
  a_exc_clear: assert property (win_q == `VFM_CNT_W'(1) && !fault_ev |=> exc_q == 3'h0)
    else $error("exception count not cleared");
endmodule // vfm_monitor
`default_nettype wire

//--- logic/vfm_pkg.sv
// Types for the VBUS fault monitor.
// Assumes nothing beyond the constants header.
`default_nettype none
package vfm_pkg;
  typedef enum logic [4:0] {
    VFM_OFF = 5'b00001,
    VFM_RAMP_ON = 5'b00010,
    VFM_ON = 5'b00100,
    VFM_RAMP_OFF = 5'b01000,
    VFM_FAULT = 5'b10000
  } vfm_state_type;
  typedef enum logic [2:0] {
    VFM_LVL_5 = 3'h0, VFM_LVL_9 = 3'h1, VFM_LVL_12 = 3'h2, VFM_LVL_16 = 3'h3, VFM_LVL_20 = 3'h4
  } vfm_level_type;
  typedef enum logic [1:0] {
    VFM_CUR_1A5 = 2'h0, VFM_CUR_2A = 2'h1, VFM_CUR_3A = 2'h2, VFM_CUR_5A = 2'h3
  } vfm_current_type;
endpackage
`default_nettype wire

//--- tb/vfm_monitor_test.sv
// Bench for the VBUS fault monitor: transitions, limits, strobe back-off.
// Assumes the design files and the supply model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module vfm_monitor_test;
  localparam int TRANS = 50;
  localparam int STROBE = 20;
  localparam int LONG = 60;
  localparam int WIN = 80;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic req = 1'b0, cv = 1'b0, pa = 1'b0, src = 1'b1, ext = 1'b0, ovr_en = 1'b0;
  logic [2:0] lvl = 3'h0;
  logic [1:0] cc = 2'h0;
  logic [11:0] cur = 12'h000, ovr = 12'h000, tgt = 12'h1f4, step = 12'h064;
  logic [11:0] mv, vb;
  logic en, dis, fn, pg;
  logic [11:0] nom [5] = '{12'h1f4, 12'h384, 12'h4b0, 12'h640, 12'h7d0};
  logic [11:0] ov [5] = '{12'h258, 12'h410, 12'h55a, 12'h712, 12'h8ca};
  logic [11:0] uv [5] = '{12'h1c2, 12'h32a, 12'h438, 12'h5a0, 12'h708};
  logic [11:0] oc [5] = '{12'h361, 12'h47e, 12'h6bd, 12'hb3b, 12'h6bd};
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int g;
  assign vb = ovr_en ? ovr : mv;
  always #20 clk_in = ~clk_in;
  vfm_supply_model SUP (.clk_in(clk_in), .nrst_in(nrst_in), .supply_en_in(en),
    .discharge_in(dis), .target_in(tgt), .step_in(step), .vbus_out(mv));
  vfm_monitor #(.TRANS_CYC(TRANS), .STROBE_CYC(STROBE), .LONG_CYC(LONG), .WIN_CYC(WIN),
    .PULSE_CYC(3)) DUT (.clk_in(clk_in), .nrst_in(nrst_in), .vbus_voltage_sense_in(vb),
    .supply_current_sense_in(cur), .external_sink_fault_in(ext), .power_on_req_in(req),
    .level_sel_in(lvl), .contract_current_in(cc), .contract_valid_in(cv),
    .partner_attached_in(pa), .sourcing_in(src), .supply_en_out(en), .discharge_out(dis),
    .fault_n_out(fn), .power_good_out(pg));
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = pg;
      1: pick = en;
      2: pick = dis;
      default: pick = fn;
    endcase
  endfunction
  task automatic wait_until(input int s, input logic v);
    for (int k = 0; k < 300; k++) begin
      @(posedge clk_in);
      #1;
      if (pick(s) === v) break;
    end
  endtask
  task automatic power_up();
    @(posedge clk_in);
    req <= 1'b1;
    wait_until(0, 1'b1);
  endtask
  task automatic recover();
    @(posedge clk_in);
    req <= 1'b0;
    ovr_en <= 1'b0;
    cur <= 12'h000;
    wait_until(2, 1'b0);
    repeat (5) @(posedge clk_in);
  endtask
  task automatic trip(input logic is_cur, input logic [11:0] ok, input logic [11:0] bad);
    power_up();
    @(posedge clk_in);
    if (is_cur)
      cur <= ok;
    ovr_en <= !is_cur;
    ovr <= ok;
    repeat (4) @(posedge clk_in);
    #1;
    `CHK("en at limit", 1'b1, en)
    @(posedge clk_in);
    if (is_cur)
      cur <= bad;
    ovr <= bad;
    wait_until(1, 1'b0);
    `CHK("en past limit", 1'b0, en)
    `CHK("dis past limit", 1'b1, dis)
    recover();
  endtask
  task automatic gap();
    logic p;
    wait_until(3, 1'b0);
    p = 1'b0;
    for (g = 1; g < 300; g++) begin
      @(posedge clk_in);
      #1;
      if (p === 1'b1 && fn === 1'b0) break;
      p = fn;
    end
  endtask
  task automatic ext_trip();
    power_up();
    @(posedge clk_in);
    ext <= 1'b1;
    wait_until(1, 1'b0);
    `CHK("en on sink fault", 1'b0, en)
    @(posedge clk_in);
    ext <= 1'b0;
  endtask
  task automatic t_onoff();
    power_up();
    `CHK("vbus at power good", 12'h190, vb)
    `CHK("power good", 1'b1, pg)
    @(posedge clk_in);
    req <= 1'b0;
    wait_until(2, 1'b1);
    wait_until(2, 1'b0);
    `CHK("vbus at discharged", 12'h064, vb)
    `CHK("en when off", 1'b0, en)
    `CHK("power good when off", 1'b0, pg)
  endtask
  task automatic t_tmo();
    // Pass 0 stalls the ramp up, pass 1 stalls the discharge
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge clk_in);
      step <= 12'h000;
      req <= (ph == 0);
      repeat (TRANS - 10) @(posedge clk_in);
      #1;
      `CHK("fault before timeout", 1'b1, fn)
      repeat (15) @(posedge clk_in);
      #1;
      `CHK("fault on timeout", 1'b0, fn)
      @(posedge clk_in);
      step <= 12'h064;
      wait_until(2 * ph, ph == 0);
      `CHK("fault after ramp done", 1'b1, fn)
    end
    recover();
  endtask
  task automatic t_limits();
    @(posedge clk_in);
    step <= 12'h1f4;
    for (int i = 0; i < 5; i++) begin
      lvl <= 3'(i);
      tgt <= nom[i];
      trip(1'b0, ov[i], ov[i] + 12'h001);
      trip(1'b0, uv[i], uv[i] - 12'h001);
    end
    lvl <= 3'h0;
    tgt <= 12'h1f4;
    for (int i = 0; i < 5; i++) begin
      cc <= 2'(i);
      cv <= (i < 4);
      pa <= (i < 4);
      trip(1'b1, oc[i], oc[i] + 12'h001);
    end
    src <= 1'b0;
    cur <= 12'hfff;
    power_up();
    repeat (6) @(posedge clk_in);
    #1;
    `CHK("en while sinking", 1'b1, en)
    @(posedge clk_in);
    src <= 1'b1;
    wait_until(1, 1'b0);
    `CHK("en when sourcing", 1'b0, en)
    recover();
  endtask
  task automatic t_backoff();
    repeat (WIN + 20) @(posedge clk_in);
    ext_trip();
    gap();
    `CHK("short interval", 1'b1, (g >= STROBE - 2 && g <= STROBE + 2))
    recover();
    ext_trip();
    recover();
    ext_trip();
    recover();
    ext_trip();
    gap();
    `CHK("long interval", 1'b1, (g >= LONG - 2 && g <= LONG + 2))
    repeat (WIN) @(posedge clk_in);
    gap();
    `CHK("interval after quiet", 1'b1, (g >= STROBE - 2 && g <= STROBE + 2))
    recover();
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_onoff();
    t_tmo();
    t_limits();
    t_backoff();
    tally_and_finish();
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
endmodule // vfm_monitor_test
`default_nettype wire

//--- tb/vfm_supply_model.sv
// Supply model: VBUS code climbs by step while enabled, falls while discharging.
// Assumes the monitor's clock and reset.
`timescale 1ns/1ns
`default_nettype none
module vfm_supply_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Control
  input wire logic supply_en_in,
  input wire logic discharge_in,
  input wire logic [11:0] target_in,
  input wire logic [11:0] step_in,
  // Sensed VBUS
  output logic [11:0] vbus_out
);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in)
      vbus_out <= 12'h000;
    else if (supply_en_in)
      vbus_out <= (vbus_out + step_in < target_in) ? vbus_out + step_in : target_in;
    else if (discharge_in)
      vbus_out <= (vbus_out > step_in) ? vbus_out - step_in : 12'h000;
  end
endmodule // vfm_supply_model
`default_nettype wire
